// >>> hw/oegd_params.svh
// constants for the opcode escape group decoder
`ifndef OEGD_PARAMS_SVH
`define OEGD_PARAMS_SVH
`define OEGD_CODE_74 8'h74
`define OEGD_CODE_75 8'h75
`define OEGD_CODE_76 8'h76
`define OEGD_CODE_77 8'h77
`define OEGD_CODE_7A 8'h7A
`define OEGD_CODE_7B 8'h7B
`define OEGD_CODE_7C 8'h7C
`define OEGD_CODE_7D 8'h7D
`define OEGD_CODE_7E 8'h7E
`define OEGD_ESC_COUNT 9
`endif

// >>> hw/oegd_pkg.sv
// types for the opcode escape group decoder
package oegd_pkg;
   typedef enum logic [2:0] {
      OEGD_GRP_NONE,
      OEGD_GRP_TRANSFER,
      OEGD_GRP_ARITH,
      OEGD_GRP_EXCHANGE_LOAD,
      OEGD_GRP_EXCHANGE_STORE,
      OEGD_GRP_EXT_C,
      OEGD_GRP_EXT_D,
      OEGD_GRP_BIT
   } oegd_group_t;
endpackage

// >>> hw/oegd_escape_match.sv
// combinational match of a first byte against the escape codes
`timescale 1ns/1ps
module oegd_escape_match
   import oegd_pkg::*;
(
   // byte under test
   input  wire logic [7:0] first_byte,
   // match results
   output oegd_group_t     group,
   output logic            is_escape
);
`include "oegd_params.svh"

   // escape byte to group
   always_comb begin
      unique case (first_byte)
         `OEGD_CODE_74, `OEGD_CODE_75: group = OEGD_GRP_TRANSFER;
         `OEGD_CODE_76, `OEGD_CODE_77: group = OEGD_GRP_ARITH;
         `OEGD_CODE_7A: group = OEGD_GRP_EXCHANGE_LOAD;
         `OEGD_CODE_7B: group = OEGD_GRP_EXCHANGE_STORE;
         `OEGD_CODE_7C: group = OEGD_GRP_EXT_C;
         `OEGD_CODE_7D: group = OEGD_GRP_EXT_D;
         `OEGD_CODE_7E: group = OEGD_GRP_BIT;
         default:       group = OEGD_GRP_NONE;
      endcase
   end

   assign is_escape = (group != OEGD_GRP_NONE);
endmodule

// >>> hw/oegd_decoder.sv
// first-stage escape group decoder for the 16-bit cpu
// What this block does
// - after an escape first byte the next byte is taken as the selector within that group.
// - first bytes 74h and 75h both open the transfer, shift and extended-space group.
// - first bytes 76h and 77h both open the arithmetic and logic group.
// - first byte 7Ch opens the first extended group.
// - first byte 7Dh opens the second extended group.
// - first byte 7Eh opens the bit manipulation group.
`timescale 1ns/1ps
module oegd_decoder
   import oegd_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // opcode bytes from fetch
   input  wire logic [7:0] op_byte,
   input  wire logic       op_valid,
   // escape indicator to fetch
   output logic            escape_pending,
   // dispatch to execution control
   output logic            dispatch_valid,
   output logic            dispatch_escaped,
   output oegd_group_t     dispatch_group,
   output logic [7:0]      dispatch_first,
   output logic [7:0]      dispatch_select
);
`include "oegd_params.svh"

   typedef enum logic {
      OEGD_ST_FIRST,
      OEGD_ST_SECOND
   } oegd_state_t;

   oegd_state_t  state;
   oegd_state_t  next_state;
   oegd_group_t  held_group;
   oegd_group_t  next_held_group;
   logic [7:0]   held_first;
   logic [7:0]   next_held_first;
   logic         next_dispatch_valid;
   logic         next_dispatch_escaped;
   oegd_group_t  next_dispatch_group;
   logic [7:0]   next_dispatch_first;
   logic [7:0]   next_dispatch_select;
   oegd_group_t  match_group;
   logic         match_escape;

   ////////////////////////////////////////////////////////////////////////
   oegd_escape_match u_match (
      .first_byte (op_byte),
      .group      (match_group),
      .is_escape  (match_escape)
   );

   // indicator is combinational so fetch sees it in the escape cycle
   assign escape_pending = (state == OEGD_ST_SECOND) ||
                           (state == OEGD_ST_FIRST && op_valid &&
                            match_escape);

   ////////////////////////////////////////////////////////////////////////
   // next-state and dispatch computation
   always_comb begin
      next_state            = state;
      next_held_group       = held_group;
      next_held_first       = held_first;
      next_dispatch_valid   = 1'b0;
      next_dispatch_escaped = dispatch_escaped;
      next_dispatch_group   = dispatch_group;
      next_dispatch_first   = dispatch_first;
      next_dispatch_select  = dispatch_select;
      unique case (state)
         OEGD_ST_FIRST: begin
            if (op_valid && match_escape) begin
               // escape byte alone never dispatches
               next_state      = OEGD_ST_SECOND;
               next_held_group = match_group;
               next_held_first = op_byte;
            end else if (op_valid) begin
               next_dispatch_valid   = 1'b1;
               next_dispatch_escaped = 1'b0;
               next_dispatch_group   = OEGD_GRP_NONE;
               next_dispatch_first   = op_byte;
               next_dispatch_select  = 8'h00;
            end
         end
         OEGD_ST_SECOND: begin
            // any byte value is a legal selector, no re-escape check
            if (op_valid) begin
               next_state            = OEGD_ST_FIRST;
               next_dispatch_valid   = 1'b1;
               next_dispatch_escaped = 1'b1;
               next_dispatch_group   = held_group;
               next_dispatch_first   = held_first;
               next_dispatch_select  = op_byte;
            end
         end
      endcase
   end

   // registers only
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state            <= OEGD_ST_FIRST;
         held_group       <= OEGD_GRP_NONE;
         held_first       <= 8'h00;
         dispatch_valid   <= 1'b0;
         dispatch_escaped <= 1'b0;
         dispatch_group   <= OEGD_GRP_NONE;
         dispatch_first   <= 8'h00;
         dispatch_select  <= 8'h00;
      end else begin
         state            <= next_state;
         held_group       <= next_held_group;
         held_first       <= next_held_first;
         dispatch_valid   <= next_dispatch_valid;
         dispatch_escaped <= next_dispatch_escaped;
         dispatch_group   <= next_dispatch_group;
         dispatch_first   <= next_dispatch_first;
         dispatch_select  <= next_dispatch_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_escape_no_dispatch: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && match_escape)
         |=> !dispatch_valid)
      else $error("escape byte dispatched alone");

   chk_select_is_second: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_SECOND && op_valid)
         |=> dispatch_valid && dispatch_escaped &&
             dispatch_select == $past(op_byte))
      else $error("second byte not used as selector");

   chk_grp_transfer: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid &&
       (op_byte == `OEGD_CODE_74 || op_byte == `OEGD_CODE_75)) ##1 op_valid
         |=> dispatch_group == OEGD_GRP_TRANSFER)
      else $error("74h/75h not transfer group");

   chk_grp_arith: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid &&
       (op_byte == `OEGD_CODE_76 || op_byte == `OEGD_CODE_77)) ##1 op_valid
         |=> dispatch_group == OEGD_GRP_ARITH)
      else $error("76h/77h not arithmetic group");

   chk_grp_xload: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && op_byte == `OEGD_CODE_7A)
         ##1 op_valid |=> dispatch_group == OEGD_GRP_EXCHANGE_LOAD)
      else $error("7Ah not exchange-load group");

   chk_grp_xstore: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && op_byte == `OEGD_CODE_7B)
         ##1 op_valid |=> dispatch_group == OEGD_GRP_EXCHANGE_STORE)
      else $error("7Bh not exchange-store group");

   chk_grp_ext_c: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && op_byte == `OEGD_CODE_7C)
         ##1 op_valid |=> dispatch_group == OEGD_GRP_EXT_C &&
                          dispatch_first == `OEGD_CODE_7C)
      else $error("7Ch not first extended group");

   chk_grp_ext_d: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && op_byte == `OEGD_CODE_7D)
         ##1 op_valid |=> dispatch_group == OEGD_GRP_EXT_D)
      else $error("7Dh not second extended group");

   chk_grp_bit: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && op_byte == `OEGD_CODE_7E)
         ##1 op_valid |=> dispatch_group == OEGD_GRP_BIT)
      else $error("7Eh not bit group");

   chk_escape_flag: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid &&
       (op_byte inside {`OEGD_CODE_74, `OEGD_CODE_75, `OEGD_CODE_76,
                        `OEGD_CODE_77, `OEGD_CODE_7A, `OEGD_CODE_7B,
                        `OEGD_CODE_7C, `OEGD_CODE_7D, `OEGD_CODE_7E}))
         |-> escape_pending ##1 escape_pending)
      else $error("escape indicator missing");

   chk_plain_single: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && !escape_pending)
         |=> dispatch_valid && !dispatch_escaped &&
             dispatch_first == $past(op_byte))
      else $error("plain byte not dispatched");

   chk_plain_no_group: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && !match_escape)
         |=> dispatch_group == OEGD_GRP_NONE && dispatch_select == 8'h00)
      else $error("plain byte given a group");

   // a pair cut by idle cycles must keep waiting, never dispatch half
   chk_wait_holds: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_SECOND && !op_valid)
         |=> state == OEGD_ST_SECOND && !dispatch_valid)
      else $error("pair abandoned while waiting");

   chk_first_kept: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == OEGD_ST_FIRST && op_valid && match_escape) ##1 op_valid
         |=> dispatch_first == $past(op_byte, 2))
      else $error("escape byte not kept as first byte");

   // execution control may read the data lines late, so they must hold
   chk_idle_stable: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !op_valid |=> !dispatch_valid && $stable(dispatch_first) &&
                    $stable(dispatch_select) && $stable(dispatch_group))
      else $error("dispatch outputs moved without a byte");

   // reset is synchronous, so its effect is seen one edge later
   chk_reset_clears: assert property (
      @(posedge ref_clk) sys_rst |=> !dispatch_valid &&
                                     state == OEGD_ST_FIRST)
      else $error("reset left a dispatch or a pending pair");
endmodule

// >>> sim/oegd_fetch_model.sv
// fetch-side stand-in that presents opcode bytes to the decoder
`timescale 1ns/1ps
module oegd_fetch_model (
   // clock and requests from the bench
   input  wire logic       ref_clk,
   input  wire logic       req_valid,
   input  wire logic [7:0] req_byte,
   // opcode bus toward the decoder
   output logic            op_valid,
   output logic [7:0]      op_byte
);
   logic [7:0] junk = 8'hA5;
   // idle bus keeps changing so a stale byte is never mistaken for data
   always @(posedge ref_clk) begin
      junk <= junk + 8'h3B;
   end
   // bytes pass straight through while a request is up
   assign op_valid = req_valid;
   assign op_byte  = req_valid ? req_byte : junk;
endmodule

// >>> sim/opcode_escape_group_decoder_test.sv
// self-checking bench for the opcode escape group decoder
`timescale 1ns/1ps
`include "oegd_params.svh"
module opcode_escape_group_decoder_test
   import oegd_pkg::*;
;
   logic        ref_clk        = 1'b0;
   logic        sys_rst        = 1'b1;
   logic        req_valid      = 1'b0;
   logic [7:0]  req_byte       = 8'h00;
   logic        waiting        = 1'b0;
   logic [7:0]  first_b        = 8'h00;
   logic [31:0] rnd            = 32'h28E88190;
   int          n_errors       = 0;
   int          total_checks   = 0;
   logic        op_valid, escape_pending, dispatch_valid, dispatch_escaped;
   logic [7:0]  op_byte, dispatch_first, dispatch_select;
   oegd_group_t dispatch_group;
   logic [19:0] exp_q[$];
   logic [7:0]  codes[15] = '{`OEGD_CODE_74, `OEGD_CODE_75, `OEGD_CODE_76,
      `OEGD_CODE_77, `OEGD_CODE_7A, `OEGD_CODE_7B, `OEGD_CODE_7C,
      `OEGD_CODE_7D, `OEGD_CODE_7E, 8'h73, 8'h78, 8'h79, 8'h7F, 8'hEB, 8'h00};

   oegd_fetch_model u_fetch (.ref_clk(ref_clk), .req_valid(req_valid),
      .req_byte(req_byte), .op_valid(op_valid), .op_byte(op_byte));
   oegd_decoder u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .op_byte(op_byte), .op_valid(op_valid),
      .escape_pending(escape_pending), .dispatch_valid(dispatch_valid),
      .dispatch_escaped(dispatch_escaped), .dispatch_group(dispatch_group),
      .dispatch_first(dispatch_first), .dispatch_select(dispatch_select));

   ////////////////////////////////////////////////////////////////////////
   // expected group of a first byte
   function automatic oegd_group_t grp(input logic [7:0] b);
      case (b)
         `OEGD_CODE_74, `OEGD_CODE_75: return OEGD_GRP_TRANSFER;
         `OEGD_CODE_76, `OEGD_CODE_77: return OEGD_GRP_ARITH;
         `OEGD_CODE_7A: return OEGD_GRP_EXCHANGE_LOAD;
         `OEGD_CODE_7B: return OEGD_GRP_EXCHANGE_STORE;
         `OEGD_CODE_7C: return OEGD_GRP_EXT_C;
         `OEGD_CODE_7D: return OEGD_GRP_EXT_D;
         `OEGD_CODE_7E: return OEGD_GRP_BIT;
         default: return OEGD_GRP_NONE;
      endcase
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one byte per call; the decoder takes it at the following edge
   task automatic send(input logic [7:0] b, input logic v);
      logic esc;
      logic exp_esc;
      @(posedge ref_clk);
      req_valid <= v;
      req_byte  <= b;
      esc = (grp(b) != OEGD_GRP_NONE);
      exp_esc = (v & esc) | waiting;
      #1 check(20'(escape_pending), 20'(exp_esc));
      if (v) begin
         if (waiting) exp_q.push_back({1'b1, grp(first_b), first_b, b});
         else if (!esc) exp_q.push_back({1'b0, OEGD_GRP_NONE, b, 8'h00});
         if (!waiting) first_b = b;
         waiting = !waiting && esc;
      end
   endtask
   task automatic do_reset(input int n);
      @(posedge ref_clk);
      sys_rst   <= 1'b1;
      req_valid <= 1'b0;
      waiting = 1'b0;
      repeat (n) @(posedge ref_clk);
      sys_rst <= 1'b0;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      test_done();
   end
   // result watcher pairs every dispatch with the oldest note
   always @(posedge ref_clk) begin
      if (!sys_rst && dispatch_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected none", $time,
               dispatch_first);
         end else begin
            check({dispatch_escaped, dispatch_group, dispatch_first,
               dispatch_select}, exp_q.pop_front());
         end
      end
   end
   initial begin
      do_reset(16);
      // all escapes back to back with selectors, then neighbour and distant singles
      foreach (codes[i]) begin
         send(codes[i], 1'b1);
         if (i < 9) send(8'h12 + 8'(i), 1'b1);
      end
      $display("test 1 done");
      // idle gap inside a pair, and an escape value used as selector
      send(`OEGD_CODE_7D, 1'b1);
      repeat (3) send(8'h00, 1'b0);
      send(`OEGD_CODE_7E, 1'b1);
      send(8'h30, 1'b1);
      $display("test 2 done");
      // reset abandons a half-taken pair
      send(`OEGD_CODE_7C, 1'b1);
      send(8'h00, 1'b0);
      do_reset(2);
      send(8'h20, 1'b1);
      $display("test 3 done");
      // random traffic biased toward the escape range
      repeat (300) begin
         rnd = xs(rnd);
         send(rnd[9] ? {4'h7, rnd[3:0]} : rnd[7:0], rnd[10] | rnd[11]);
      end
      repeat (3) send(8'h00, 1'b0);
      check(20'(exp_q.size()), 20'h0);
      $display("test 4 done");
      test_done();
   end
endmodule
